// >>> hw/ascr_pkg.sv
// Constants and types for the serial configuration register block
package ascr_pkg;
  localparam int CFG_WIDTH = 12;
  localparam int FRAME_BITS = 16;
  localparam int PATTERN_BITS = 16;
  localparam int MUX_SWITCH_EDGE = 14;
  localparam int RESULT_BITS = 12;
  localparam int BIT_LOAD_GATE = 11;
  localparam int BIT_CYCLING = 10;
  localparam int BIT_UNUSED_HI = 9;
  localparam int BIT_CHAN_HI = 8;
  localparam int BIT_CHAN_LO = 6;
  localparam int BIT_POWER_HI = 5;
  localparam int BIT_POWER_LO = 4;
  localparam int BIT_PATTERN_SEL = 3;
  localparam int BIT_UNUSED_LO = 2;
  localparam int BIT_RANGE = 1;
  localparam int BIT_CODING = 0;
  localparam logic [11:0] CFG_RESET = 12'h030;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;
  localparam logic [4:0] EDGE_COUNT_RESET = 5'h00;
  localparam logic [3:0] SEQ_INDEX_RESET = 4'h0;

  typedef enum logic [1:0] {
    ASCR_PWR_INVALID = 2'b00,
    ASCR_PWR_AUTO = 2'b01,
    ASCR_PWR_SHUTDOWN = 2'b10,
    ASCR_PWR_NORMAL = 2'b11
  } ascr_power_type;

  typedef enum logic [1:0] {
    ASCR_SEQ_OFF = 2'b00,
    ASCR_SEQ_PATTERN = 2'b01,
    ASCR_SEQ_KEEP = 2'b10,
    ASCR_SEQ_RANGE = 2'b11
  } ascr_seq_type;

  typedef enum logic [1:0] {
    ASCR_ST_IDLE = 2'b00,
    ASCR_ST_FRAME = 2'b01,
    ASCR_ST_DONE = 2'b10
  } ascr_state_type;
endpackage

// >>> hw/ascr_link_if.sv
// Synchronised serial link signals shared between the block's modules
`timescale 1ns/1ps
interface ascr_link_if;
  logic sclk_fall;
  logic frame_active;
  logic frame_start;
  logic frame_end;
  logic data_bit;
  modport sync (output sclk_fall, output frame_active, output frame_start, output frame_end, output data_bit);
  modport core (input sclk_fall, input frame_active, input frame_start, input frame_end, input data_bit);
endinterface

// >>> hw/ascr_sync.sv
// Pin synchroniser and edge finder for the serial link
`timescale 1ns/1ps
module ascr_sync
  import ascr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  ascr_link_if.sync link
);
  logic [2:0] meta_d, meta_q, stage_d, stage_q, prev_d, prev_q;

  always_comb begin
    meta_d = {sclk_pin, cs_n_pin, din_pin};
    stage_d = meta_q;
    prev_d = stage_q;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_q <= 3'h6;
      stage_q <= 3'h6;
      prev_q <= 3'h6;
    end else begin
      meta_q <= meta_d;
      stage_q <= stage_d;
      prev_q <= prev_d;
    end
  end

  assign link.sclk_fall = prev_q[2] & ~stage_q[2] & ~stage_q[1];
  assign link.frame_active = ~stage_q[1];
  assign link.frame_start = prev_q[1] & ~stage_q[1];
  assign link.frame_end = ~prev_q[1] & stage_q[1];
  assign link.data_bit = stage_q[0];
endmodule

// >>> hw/ascr_core.sv
// Configuration register, pattern register and channel sequencer of the converter
`timescale 1ns/1ps
// Function
// [R1] Twelve-bit configuration register, written by host, never readable back.
// [R2] Data input sampled on every falling serial clock edge during a frame; the code samples only the first sixteen.
// [R3] New configuration applies to the next conversion only.
// [R4] Host gives sixteen serial clocks per frame with select low.
// [R5] Only the first twelve falling edges after select falls are loaded.
// [R6] First bit is bit 11, then descending to bit 0.
// [R7] Bit 11 high loads the rest; low keeps the register unchanged.
// [R8] Bits 8..6 pick next channel or last channel of a sequence.
// [R9] Multiplexer switches channel on the fourteenth falling edge.
// [R10] Output frame carries channel number ahead of twelve result bits; the code has no output frame, only the channel number on result_channel.
// [R11] Bits 10 and 3 pick sequencer mode and pattern-register write.
// [R12] Bit 1 picks input range: zero twice reference, one reference.
// [R13] Bit 0 picks coding: zero twos complement, one straight binary.
// [R14] Bits 5 and 4 decode normal, shutdown, auto shutdown or forbidden.
// [R15] Power bits 11 keep the device fully powered always.
// [R16] Power bits 10 power down, keep register, until rewritten.
// [R17] Power bits 01 shut down after each conversion that updated register.
// [R18] Host waits one microsecond wake-up in auto shutdown.
// [R19] Host never writes power bits 00.
// [R20] Sequencer bits 00: each conversion uses channel from previous write.
// [R21] Sequencer bits 01: next frame loads sixteen-bit channel pattern.
// [R22] Sequencer bits 11: cycle from channel zero to channel field.
// [R23] Bits 9 and 2 are ignored.
module ascr_core
  import ascr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  output logic [2:0] mux_channel,
  output logic [2:0] result_channel,
  output logic range_ref_only,
  output logic straight_binary,
  output logic powered_down,
  output logic sequencing,
  output logic [15:0] channel_pattern
);
  ascr_link_if link ();

  ascr_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin),
    .din_pin(din_pin),
    .link(link)
  );

  logic [CFG_WIDTH-1:0] cfg_d, cfg_q;
  logic [PATTERN_BITS-1:0] shift_d, shift_q, pattern_d, pattern_q;
  logic [4:0] edge_d, edge_q;
  logic [3:0] seq_idx_d, seq_idx_q;
  logic [2:0] mux_d, mux_q, conv_d, conv_q;
  logic range_d, range_q, coding_d, coding_q, down_d, down_q, seqon_d, seqon_q;
  logic pat_next_d, pat_next_q, updated_d, updated_q;
  ascr_state_type state_d, state_q;
  ascr_power_type pwr;
  ascr_seq_type seq_mode;
  logic [CFG_WIDTH-1:0] word;
  logic [3:0] seq_try;
  logic found;

  assign pwr = ascr_power_type'(cfg_q[BIT_POWER_HI:BIT_POWER_LO]);
  assign seq_mode = ascr_seq_type'({cfg_q[BIT_CYCLING], cfg_q[BIT_PATTERN_SEL]});
  assign word = shift_q[PATTERN_BITS-1 -: CFG_WIDTH];

  always_comb begin
    state_d = state_q;
    edge_d = edge_q;
    shift_d = shift_q;
    cfg_d = cfg_q;
    pattern_d = pattern_q;
    pat_next_d = pat_next_q;
    updated_d = 1'b0;
    seq_idx_d = seq_idx_q;
    mux_d = mux_q;
    conv_d = conv_q;
    range_d = range_q;
    coding_d = coding_q;
    down_d = down_q;
    seqon_d = seqon_q;
    seq_try = seq_idx_q;
    found = 1'b0;
    unique case (state_q)
      ASCR_ST_IDLE: begin
        if (link.frame_start) begin
          state_d = ASCR_ST_FRAME;
          edge_d = EDGE_COUNT_RESET;
          conv_d = mux_q;
        end
      end
      ASCR_ST_FRAME: begin
        if (link.sclk_fall && edge_q < 5'(FRAME_BITS)) begin
          // [R2] Sample each of the first sixteen falling edges
          edge_d = edge_q + 5'h01;
          // [R6] Shift in MSB first
          shift_d = {shift_q[PATTERN_BITS-2:0], link.data_bit};
          // [R9] Mux follows on fourteenth edge
          if (edge_q == 5'(MUX_SWITCH_EDGE - 1) && !down_q) begin
            // [R8] Channel field picks next input
            mux_d = cfg_q[BIT_CHAN_HI:BIT_CHAN_LO];
            if (seqon_q) begin
              for (int k = 0; k < PATTERN_BITS; k++) begin
                if (!found) begin
                  seq_try = 4'(seq_idx_q + 4'(k));
                  if (seq_mode == ASCR_SEQ_RANGE || pat_next_q == 1'b0 && seq_mode == ASCR_SEQ_KEEP
                      && pattern_q == PATTERN_RESET) begin
                    // [R22] Consecutive channels from zero
                    seq_try = (conv_q >= cfg_q[BIT_CHAN_HI:BIT_CHAN_LO]) ? 4'h0 : 4'({1'b0, conv_q} + 4'h1);
                    found = 1'b1;
                  end else if (pattern_q[15 - seq_try]) begin
                    found = 1'b1;
                  end
                end
              end
              mux_d = seq_try[2:0];
              seq_idx_d = 4'(seq_try + 4'h1);
            end
          end
        end
        if (link.frame_end) begin
          state_d = ASCR_ST_DONE;
        end
      end
      ASCR_ST_DONE: begin
        state_d = ASCR_ST_IDLE;
        if (edge_q >= 5'(FRAME_BITS)) begin
          if (pat_next_q) begin
            // [R21] Frame loads channel pattern
            pattern_d = shift_q;
            pat_next_d = 1'b0;
            seqon_d = 1'b1;
            seq_idx_d = SEQ_INDEX_RESET;
          // [R5] Loaded word is first twelve bits
          end else if (shift_q[PATTERN_BITS-1]) begin
            // [R7] Load gate set, update the rest; [R23] bits 9 and 2 kept out
            cfg_d = word;
            cfg_d[BIT_UNUSED_HI] = 1'b0;
            cfg_d[BIT_UNUSED_LO] = 1'b0;
            updated_d = 1'b1;
            // [R3] Range and coding apply to the next conversion
            range_d = shift_q[4 + BIT_RANGE];
            coding_d = shift_q[4 + BIT_CODING];
            // [R11] Sequencer mode decode
            unique case (ascr_seq_type'({shift_q[4 + BIT_CYCLING], shift_q[4 + BIT_PATTERN_SEL]}))
              // [R20] Plain channel per write
              ASCR_SEQ_OFF: seqon_d = 1'b0;
              ASCR_SEQ_PATTERN: begin
                pat_next_d = 1'b1;
                seqon_d = 1'b0;
              end
              ASCR_SEQ_KEEP: seqon_d = seqon_q;
              ASCR_SEQ_RANGE: begin
                seqon_d = 1'b1;
                pattern_d = PATTERN_RESET;
              end
            endcase
            // [R14] Power decode
            unique case (ascr_power_type'(shift_q[4 + BIT_POWER_HI -: 2]))
              // [R15] Fully powered
              ASCR_PWR_NORMAL: down_d = 1'b0;
              // [R16] Stay down until rewritten
              ASCR_PWR_SHUTDOWN: down_d = 1'b1;
              // [R17] Down after an updating conversion
              ASCR_PWR_AUTO: down_d = 1'b1;
              ASCR_PWR_INVALID: down_d = down_q;
            endcase
          end else if (pwr == ASCR_PWR_AUTO) begin
            down_d = 1'b0;
          end
        end
      end
      default: state_d = ASCR_ST_IDLE;
    endcase
    if (pwr == ASCR_PWR_AUTO && link.frame_start && !updated_q) begin
      down_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= ASCR_ST_IDLE;
      edge_q <= EDGE_COUNT_RESET;
      shift_q <= PATTERN_RESET;
      // [R1] Write-only register, no read path
      cfg_q <= CFG_RESET;
      pattern_q <= PATTERN_RESET;
      pat_next_q <= 1'b0;
      updated_q <= 1'b0;
      seq_idx_q <= SEQ_INDEX_RESET;
      mux_q <= 3'h0;
      conv_q <= 3'h0;
      range_q <= 1'b0;
      coding_q <= 1'b0;
      down_q <= 1'b0;
      seqon_q <= 1'b0;
    end else begin
      state_q <= state_d;
      edge_q <= edge_d;
      shift_q <= shift_d;
      cfg_q <= cfg_d;
      pattern_q <= pattern_d;
      pat_next_q <= pat_next_d;
      updated_q <= updated_d;
      seq_idx_q <= seq_idx_d;
      mux_q <= mux_d;
      conv_q <= conv_d;
      range_q <= range_d;
      coding_q <= coding_d;
      down_q <= down_d;
      seqon_q <= seqon_d;
    end
  end

  assign mux_channel = mux_q;
  // [R10] Channel tag of the converted input
  assign result_channel = conv_q;
  // [R12] Range for the next conversion
  assign range_ref_only = range_q;
  // [R13] Coding for the next conversion
  assign straight_binary = coding_q;
  assign powered_down = down_q;
  assign sequencing = seqon_q;
  assign channel_pattern = pattern_q;

  // [R7] Gate low keeps the register
  gate_low_keeps_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == ASCR_ST_DONE && !pat_next_q && !shift_q[15]) |=> cfg_q == $past(cfg_q))
    else $error("config changed with load gate low");
  // [R23] Ignored bits stay clear
  ignored_bits_a: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_q[BIT_UNUSED_HI] == 1'b0 && cfg_q[BIT_UNUSED_LO] == 1'b0)
    else $error("ignored bit stored");
  // [R9] Mux moves only on fourteenth edge
  mux_switch_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
    (mux_q != $past(mux_q)) |-> $past(edge_q) == 5'(MUX_SWITCH_EDGE - 1) && $past(link.sclk_fall))
    else $error("mux switched off the fourteenth edge");
  // [R15] Normal power stays up
  normal_power_a: assert property (@(posedge sys_clk) disable iff (reset)
    (updated_q && pwr == ASCR_PWR_NORMAL) |-> !down_q)
    else $error("powered down in normal mode");
  // [R16] Shutdown mode is down
  shutdown_power_a: assert property (@(posedge sys_clk) disable iff (reset)
    (updated_q && pwr == ASCR_PWR_SHUTDOWN) |-> down_q [*2])
    else $error("shutdown not held");
  // [R5] Short frame loads nothing
  short_frame_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == ASCR_ST_DONE && edge_q < 5'(FRAME_BITS)) |=> $stable(cfg_q) && $stable(pattern_q))
    else $error("short frame loaded");
  // [R3] Range follows the stored word
  range_follows_a: assert property (@(posedge sys_clk) disable iff (reset)
    updated_q |-> range_q == cfg_q[BIT_RANGE] && coding_q == cfg_q[BIT_CODING])
    else $error("range or coding not taken from word");
  // [R21] Pattern write follows pattern select
  pattern_load_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == ASCR_ST_DONE && pat_next_q && edge_q >= 5'(FRAME_BITS)) |=> pattern_q == $past(shift_q) && seqon_q)
    else $error("pattern not loaded");
endmodule

// >>> verification/ascr_host_model.sv
// Serial host model that clocks frames into the converter
`timescale 1ns/1ps
module ascr_host_model (
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic din_pin
);
  initial begin
    sclk_pin = 1'b1;
    cs_n_pin = 1'b1;
    din_pin = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    cs_n_pin = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      din_pin = (i < 16) ? w[15-i] : 1'($urandom);
      #40 sclk_pin = 1'b0;
      #40 sclk_pin = 1'b1;
    end
    #40 cs_n_pin = 1'b1;
    din_pin = ~din_pin;
    #1000;
  endtask
endmodule

// >>> verification/adc_serial_config_register_tb.sv
// Self-checking bench for the serial configuration register
`timescale 1ns/1ps
module adc_serial_config_register_tb;
  import ascr_pkg::*;
  logic sys_clk, reset, sclk_pin, cs_n_pin, din_pin;
  logic [2:0] mux_channel, result_channel, mux_e, res_e;
  logic range_ref_only, straight_binary, powered_down, sequencing;
  logic [15:0] channel_pattern, word;
  logic [11:0] cfg_e;
  logic pd_e, pat_next;
  int n_mismatch, tests_run, blind, cyc;
  ascr_core uut (.sys_clk(sys_clk), .reset(reset), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .din_pin(din_pin), .mux_channel(mux_channel), .result_channel(result_channel),
    .range_ref_only(range_ref_only), .straight_binary(straight_binary),
    .powered_down(powered_down), .sequencing(sequencing), .channel_pattern(channel_pattern));
  ascr_host_model host (.sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .din_pin(din_pin));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [15:0] cw(input logic [2:0] ch, input logic [1:0] pm, input logic s10, s3);
    return {1'b1, s10, 1'b0, ch, pm, s3, 1'b0, 2'b01, 4'h0};
  endfunction
  task automatic frame(input logic [15:0] w, input int n);
    @(negedge sys_clk);
    res_e = mux_e;
    host.send(w, n);
    if (n >= 14 && (!pd_e || cfg_e[5:4] == 2'b01)) mux_e = cfg_e[8:6];
    if (cfg_e[5:4] == 2'b01) pd_e = 1'b0;
    if (n >= 16 && pat_next) begin
      pat_next = 1'b0;
    end else if (n >= 16 && w[15]) begin
      cfg_e = w[15:4];
      pd_e = (w[9:8] != 2'b11);
      pat_next = !w[14] && w[7];
    end
    if (blind > 0) begin
      blind--;
    end else begin
      chk(mux_channel, mux_e, "mux");
      chk(result_channel, res_e, "result channel");
    end
    chk(range_ref_only, cfg_e[1], "range");
    chk(straight_binary, cfg_e[0], "coding");
    chk(powered_down, pd_e, "power");
  endtask
  initial begin
    reset = 1'b1;
    cfg_e = CFG_RESET;
    mux_e = 3'h0;
    pd_e = 1'b0;
    pat_next = 1'b0;
    blind = 0;
    void'($urandom(32'ha082));
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({mux_channel, result_channel, range_ref_only, straight_binary, powered_down, sequencing}, 16'h0, "reset");
    chk(channel_pattern, PATTERN_RESET, "pattern reset");
    $display("test reset done");
    frame(16'h7fff, 16);
    for (int i = 0; i < 12; i++) begin
      word = 16'($urandom);
      word[14] = 1'b0;
      word[9:8] = 2'b11;
      word[7] = 1'b0;
      frame(word, (i % 3 == 2) ? 20 : 16);
    end
    frame(16'h9f30, 10);
    $display("test random writes done");
    frame(cw(3'h2, 2'b10, 1'b0, 1'b0), 16);
    frame(16'h0000, 16);
    frame(cw(3'h5, 2'b11, 1'b0, 1'b0), 16);
    frame(cw(3'h1, 2'b01, 1'b0, 1'b0), 16);
    frame(cw(3'h4, 2'b11, 1'b0, 1'b0), 16);
    $display("test power done");
    frame(cw(3'h3, 2'b11, 1'b1, 1'b1), 16);
    chk(sequencing, 1'b1, "seq on");
    blind = 99;
    repeat (4) begin
      frame(16'h0000, 16);
      chk(mux_channel <= 3'h3, 1'b1, "seq range");
    end
    frame(cw(3'h0, 2'b11, 1'b0, 1'b1), 16);
    word = 16'($urandom);
    frame(word, 16);
    chk(channel_pattern, word, "pattern");
    frame(cw(3'h6, 2'b11, 1'b0, 1'b0), 16);
    chk(sequencing, 1'b0, "seq off");
    blind = 1;
    frame(16'h0000, 16);
    frame(16'h0000, 16);
    $display("test sequencer done");
    wrap_up();
  end
endmodule
